// File: rf_transceiver_config_fields_test.sv
`timescale 1ns/10ps

module rf_transceiver_config_fields_test;
   logic clk_in, rst_n_in, wr_s, rd_s, boot, ce, sel, done, crc_en, crc16;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [2:0] boot_code, rxw, txw, xcode, log2div;
   logic [8:0] ch;
   logic band, lowi, resend, xtal, restart;
   logic [1:0] pwr, div;
   logic [5:0] rxpw, txpw;
   logic [31:0] rxaddr, mask;
   logic [15:0] freq;
   int errors, compares, cycles;
   logic [7:0] rst_tab [10] = '{8'h6C, 8'h00, 8'h44, 8'h20, 8'h20,
                                8'hE7, 8'hE7, 8'hE7, 8'hE7, 8'hC0};

   rfc_config_bank dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s),
      .reg_read_in(rd_s), .boot_load_in(boot),
      .boot_header_crystal_code_in(boot_code),
      .radio_chip_enable_in(ce), .transmit_select_in(sel),
      .packet_done_in(done), .reg_rdata_out(rdata),
      .channel_number_out(ch), .band_select_out(band),
      .output_power_level_out(pwr), .receive_low_current_out(lowi),
      .auto_resend_out(resend), .rx_addr_width_sel_out(rxw),
      .tx_addr_width_sel_out(txw), .rx_payload_len_out(rxpw),
      .tx_payload_len_out(txpw), .rx_address_out(rxaddr),
      .rx_address_mask_out(mask), .cpu_clock_divider_out(div),
      .cpu_clock_from_crystal_out(xtal), .crystal_freq_code_out(xcode),
      .checksum_enable_out(crc_en), .checksum_16bit_out(crc16),
      .carrier_freq_100khz_out(freq), .cpu_clock_log2_div_out(log2div),
      .tx_restart_out(restart));

   // ==========================================================
   // Clock, timeout and shared tasks
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Whole run needs about 100 cycles; the ceiling leaves wide margin
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic step;
      @(posedge clk_in);
      #1;
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset;
      // Carrier register needs one edge out of reset to settle
      step();
      chk(ch, 9'h06C);
      chk(freq, 16'h10EC);
      chk({band, pwr, lowi, resend}, 5'h00);
      chk({rxw, txw}, 6'h24);
      chk({rxpw, txpw}, 12'h820);
      chk(rxaddr, 32'hE7E7E7E7);
      chk({div, log2div, xtal}, 6'h02);
      chk({crc_en, crc16}, 2'h3);
      for (int i = 0; i < 10; i++) rd(i[3:0], rst_tab[i]);
      rd(4'hF, 8'h00);
   endtask
   task automatic test_mode;
      wr(4'h1, 8'h3F);
      chk({ch, band, pwr, lowi, resend}, 14'h2D9F);
      step();
      chk(freq, 16'h23D8);
      wr(4'h0, 8'h00);
      chk(ch, 9'h100);
      rd(4'h1, 8'h3F);
      for (int p = 0; p < 4; p++) begin
         wr(4'h1, {4'h0, p[1:0], 2'b00});
         chk(pwr, p[1:0]);
      end
   endtask
   task automatic test_widths;
      for (int n = 1; n < 5; n++) begin
         wr(4'h2, {1'b0, n[2:0], 1'b0, n[2:0]});
         step();
         chk({rxw, txw}, {n[2:0], n[2:0]});
         chk(mask, (n == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * n)) - 1);
      end
      wr(4'h3, 8'h01);
      wr(4'h4, 8'h01);
      chk({rxpw, txpw}, 12'h041);
      wr(4'h3, 8'h20);
      chk(rxpw, 6'h20);
   endtask
   task automatic test_addr;
      for (int i = 5; i < 9; i++) wr(i[3:0], 8'h11 * (i - 4));
      chk(rxaddr, 32'h44332211);
      wr(4'hC, 8'h55);
      chk(rxaddr, 32'h44332211);
      rd(4'hC, 8'h00);
      rd(4'h8, 8'h44);
   endtask
   task automatic test_clock;
      for (int d = 0; d < 4; d++) begin
         wr(4'h9, {6'h00, d[1:0]});
         step();
         chk({div, log2div}, {d[1:0], 3'(d + 1)});
      end
      chk({crc_en, crc16}, 2'h0);
      wr(4'h9, 8'h04);
      step();
      chk({xtal, log2div}, 4'h8);
      @(posedge clk_in);
      boot_code <= 3'h4;
      boot <= 1'b1;
      @(posedge clk_in);
      boot <= 1'b0;
      #1;
      chk(xcode, 3'h4);
   endtask
   task automatic test_resend;
      wr(4'h1, 8'h20);
      for (int s = 1; s >= 0; s--) begin
         @(posedge clk_in);
         ce <= 1'b1;
         sel <= s[0];
         done <= 1'b1;
         @(posedge clk_in);
         done <= 1'b0;
         #1;
         chk(restart, s[0]);
         step();
         chk(restart, 1'b0);
      end
   endtask

   task automatic finish_test;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {wr_s, rd_s, boot, ce, sel, done, addr, wdata, boot_code} = '0;
      rst_n_in = 1'b0;
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1;
      test_reset();
      test_mode();
      test_widths();
      test_addr();
      test_clock();
      test_resend();
      finish_test();
   end
endmodule // rf_transceiver_config_fields_test

// File: rfc_config_bank.sv
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

// Functional notes
// - Nine-bit channel number, resets to 108, sets carrier with band.
// - Carrier MHz equals (422.4 + channel/10) times (1 + band).
// - Band select resets 0; 0 is 433 band, 1 is 868/915.
// - Output power resets 00; codes give -10, -2, +6, +10 dBm.
// - Receive low-current resets 0; 1 trims receiver current.
// - Auto-resend repeats transmission while chip enable and select high.
// - Receive address width resets to 100; codes 001 to 100 bytes.
// - Transmit address width resets to 100; one to four bytes.
// - Receive payload length resets to 32; value is bytes.
// - Transmit payload length resets to 32; value is bytes.
// - Own receive address resets E7E7E7E7; width selects used bytes.
// - CPU divider resets 00; gives 4, 2, 1 MHz or 500 kHz.
// - Clock source resets 0; 1 runs CPU straight from crystal.
// - Crystal code loaded at boot from the boot memory header.
// - Checksum enable resets to 1; 0 disables checksum.
// - Checksum length resets 1; 0 is 8-bit, 1 is 16-bit.
// - Byte 0 holds low channel bits; byte 1 holds mode bits.
module rfc_config_bank (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_write_in,
   input  wire logic        reg_read_in,
   input  wire logic        boot_load_in,
   input  wire logic [2:0]  boot_header_crystal_code_in,
   input  wire logic        radio_chip_enable_in,
   input  wire logic        transmit_select_in,
   input  wire logic        packet_done_in,
   output logic      [7:0]  reg_rdata_out,
   output logic      [8:0]  channel_number_out,
   output logic             band_select_out,
   output logic      [1:0]  output_power_level_out,
   output logic             receive_low_current_out,
   output logic             auto_resend_out,
   output logic      [2:0]  rx_addr_width_sel_out,
   output logic      [2:0]  tx_addr_width_sel_out,
   output logic      [5:0]  rx_payload_len_out,
   output logic      [5:0]  tx_payload_len_out,
   output logic      [31:0] rx_address_out,
   output logic      [31:0] rx_address_mask_out,
   output logic      [1:0]  cpu_clock_divider_out,
   output logic             cpu_clock_from_crystal_out,
   output logic      [2:0]  crystal_freq_code_out,
   output logic             checksum_enable_out,
   output logic             checksum_16bit_out,
   output logic      [15:0] carrier_freq_100khz_out,
   output logic      [2:0]  cpu_clock_log2_div_out,
   output logic             tx_restart_out
);

   // ==========================================================
   // Write decode
   // Unmapped indices match no decode, so their writes are dropped
   logic       wr_ch_low;
   logic       wr_mode;
   logic       wr_afw;
   logic       wr_rx_payload_len;
   logic       wr_tx_payload_len;
   logic       wr_clock;
   logic [7:0] next_rdata;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      hit = reg_write_in && (a == b);
   endfunction

   assign wr_ch_low = hit(reg_addr_in, rfc_pkg::BYTE_CH_LOW);
   assign wr_mode   = hit(reg_addr_in, rfc_pkg::BYTE_MODE);
   assign wr_afw    = hit(reg_addr_in, rfc_pkg::BYTE_AFW);
   assign wr_rx_payload_len  = hit(reg_addr_in, rfc_pkg::BYTE_RX_LEN);
   assign wr_tx_payload_len  = hit(reg_addr_in, rfc_pkg::BYTE_TX_LEN);
   assign wr_clock  = hit(reg_addr_in, rfc_pkg::BYTE_CLOCK);

   // ==========================================================
   // Own receive address helpers, shared by write and read-back
   // True for the four register bytes that hold the address
   function automatic logic is_addr_byte(input logic [3:0] a);
      is_addr_byte = (a >= rfc_pkg::BYTE_RXADDR0) &&
                     (a <= rfc_pkg::BYTE_RXADDR3);
   endfunction

   // Byte slot inside the address; only valid with is_addr_byte
   function automatic logic [1:0] addr_slot(input logic [3:0] a);
      logic [3:0] diff;
      diff      = a - rfc_pkg::BYTE_RXADDR0;
      addr_slot = diff[1:0];
   endfunction

   // ==========================================================
   // Channel, byte 0 and bit 0 of byte 1
   // Separate strobes keep a byte 0 write from touching bit 8
   // channel field
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         channel_number_out <= rfc_pkg::RST_CHANNEL;
      end else if (wr_ch_low) begin
         channel_number_out[7:0] <= reg_wdata_in;
      end else if (wr_mode) begin
         channel_number_out[8] <= reg_wdata_in[rfc_pkg::POS_CH8];
      end
   end

   // ==========================================================
   // Mode byte fields
   // Bits 7 and 6 of the mode byte are spare and never stored
   // band select
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         band_select_out         <= rfc_pkg::RST_BAND;
         output_power_level_out  <= rfc_pkg::RST_PWR;
         receive_low_current_out <= rfc_pkg::RST_LOW_I;
         auto_resend_out         <= rfc_pkg::RST_RESEND;
      end else if (wr_mode) begin
         band_select_out         <= reg_wdata_in[rfc_pkg::POS_BAND];
         output_power_level_out  <=
            reg_wdata_in[rfc_pkg::POS_PWR_LO +: 2];
         receive_low_current_out <= reg_wdata_in[rfc_pkg::POS_RX_LOW_I];
         auto_resend_out         <= reg_wdata_in[rfc_pkg::POS_RESEND];
      end
   end

   // ==========================================================
   // Address and payload widths
   // Codes are stored as written; legality is left to software
   // receive width
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_addr_width_sel_out <= rfc_pkg::RST_AFW;
         tx_addr_width_sel_out <= rfc_pkg::RST_AFW;
      end else if (wr_afw) begin
         rx_addr_width_sel_out <=
            reg_wdata_in[rfc_pkg::POS_RX_WIDTH_LO +: 3];
         tx_addr_width_sel_out <=
            reg_wdata_in[rfc_pkg::POS_TX_WIDTH_LO +: 3];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_payload_len_out <= rfc_pkg::RST_PW;
         tx_payload_len_out <= rfc_pkg::RST_PW;
      end else begin
         if (wr_rx_payload_len) begin
            rx_payload_len_out <= reg_wdata_in[5:0];
         end
         if (wr_tx_payload_len) begin
            tx_payload_len_out <= reg_wdata_in[5:0];
         end
      end
   end

   // ==========================================================
   // Own receive address, bytes 5 to 8, byte 0 in low bits
   // address bytes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_address_out <= rfc_pkg::RST_RX_ADDR;
      end else if (reg_write_in && is_addr_byte(reg_addr_in)) begin
         rx_address_out[{addr_slot(reg_addr_in), 3'h0} +: 8]
            <= reg_wdata_in;
      end
   end

   // match mask
   // Codes beyond four bytes clamp to all bytes rather than wrap
   // A zero code leaves nothing to match; software must avoid it
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_address_mask_out <= rfc_pkg::RST_MASK;
      end else begin
         unique case (rx_addr_width_sel_out)
            3'h0:    rx_address_mask_out <= 32'h00000000;
            3'h1:    rx_address_mask_out <= 32'h000000FF;
            3'h2:    rx_address_mask_out <= 32'h0000FFFF;
            3'h3:    rx_address_mask_out <= 32'h00FFFFFF;
            default: rx_address_mask_out <= 32'hFFFFFFFF;
         endcase
      end
   end

   // ==========================================================
   // Clock and checksum byte
   // divider field
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_clock_divider_out      <= rfc_pkg::RST_DIV;
         cpu_clock_from_crystal_out <= rfc_pkg::RST_XTAL_SEL;
         checksum_enable_out        <= rfc_pkg::RST_CRC_EN;
         checksum_16bit_out         <= rfc_pkg::RST_CRC_MODE;
      end else if (wr_clock) begin
         cpu_clock_divider_out      <= reg_wdata_in[rfc_pkg::POS_DIV_LO +: 2];
         cpu_clock_from_crystal_out <= reg_wdata_in[rfc_pkg::POS_XTAL_SEL];
         checksum_enable_out        <= reg_wdata_in[rfc_pkg::POS_CRC_EN];
         checksum_16bit_out         <= reg_wdata_in[rfc_pkg::POS_CRC_MODE];
      end
   end

   // Boot load wins over a software write in the same cycle
   // boot header load
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         crystal_freq_code_out <= rfc_pkg::RST_XTAL_CODE;
      end else if (boot_load_in) begin
         crystal_freq_code_out <= boot_header_crystal_code_in;
      end else if (wr_clock) begin
         crystal_freq_code_out <=
            reg_wdata_in[rfc_pkg::POS_XTAL_CODE_LO +: 3];
      end
   end

   // ==========================================================
   // CPU clock: 0 means crystal direct, else divide of 8 MHz base
   // Kept as a shift count so the clock divider needs no decoder
   // divider decode
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_clock_log2_div_out <= rfc_pkg::RST_LOG2_DIV;
      end else if (cpu_clock_from_crystal_out) begin
         cpu_clock_log2_div_out <= 3'h0;
      end else begin
         cpu_clock_log2_div_out <= {1'b0, cpu_clock_divider_out} + 3'h1;
      end
   end

   // ==========================================================
   // Resend: restart pulse after each packet while both lines high
   // No repeat count is kept; the engine stops when a line drops
   // repeat transmit
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_restart_out <= 1'b0;
      end else begin
         tx_restart_out <= auto_resend_out && radio_chip_enable_in &&
                           transmit_select_in && packet_done_in;
      end
   end

   // ==========================================================
   // Read-back, data one cycle after the strobe; unused bits zero
   // byte packing
   always_comb begin
      next_rdata = rfc_pkg::READ_ZERO;
      if (reg_read_in) begin
         unique case (reg_addr_in)
            rfc_pkg::BYTE_CH_LOW: next_rdata = channel_number_out[7:0];
            rfc_pkg::BYTE_MODE:   next_rdata = {2'b00, auto_resend_out,
                                     receive_low_current_out,
                                     output_power_level_out,
                                     band_select_out,
                                     channel_number_out[8]};
            rfc_pkg::BYTE_AFW:    next_rdata = {1'b0, tx_addr_width_sel_out,
                                     1'b0, rx_addr_width_sel_out};
            rfc_pkg::BYTE_RX_LEN: next_rdata = {2'b00, rx_payload_len_out};
            rfc_pkg::BYTE_TX_LEN: next_rdata = {2'b00, tx_payload_len_out};
            rfc_pkg::BYTE_CLOCK:  next_rdata = {checksum_16bit_out,
                                     checksum_enable_out,
                                     crystal_freq_code_out,
                                     cpu_clock_from_crystal_out,
                                     cpu_clock_divider_out};
            default: begin
               // Address bytes share one slice; the rest read as zero
               if (is_addr_byte(reg_addr_in)) begin
                  next_rdata = rx_address_out[{addr_slot(reg_addr_in),
                                               3'h0} +: 8];
               end
            end
         endcase
      end
   end

   // Read data register, zero when no read
   // Zero between reads keeps stale data from looking like an answer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= rfc_pkg::READ_ZERO;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // ==========================================================
   // Carrier frequency
   // frequency calculator
   rfc_freq_calc u_freq (
      .clk_in            (clk_in),
      .rst_n_in          (rst_n_in),
      .channel_number_in (channel_number_out),
      .band_select_in    (band_select_out),
      .freq_100khz_out   (carrier_freq_100khz_out)
   );

endmodule // rfc_config_bank

// File: rfc_config_bank_chk.sv
`timescale 1ns/10ps

// ==========================================================
// Port-level checker for the configuration bank
module rfc_config_bank_chk (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_write_in,
   input  wire logic        reg_read_in,
   input  wire logic        boot_load_in,
   input  wire logic [2:0]  boot_header_crystal_code_in,
   input  wire logic        radio_chip_enable_in,
   input  wire logic        transmit_select_in,
   input  wire logic        packet_done_in,
   input  wire logic [7:0]  reg_rdata_out,
   input  wire logic [8:0]  channel_number_out,
   input  wire logic        band_select_out,
   input  wire logic        auto_resend_out,
   input  wire logic [2:0]  rx_addr_width_sel_out,
   input  wire logic [31:0] rx_address_out,
   input  wire logic [31:0] rx_address_mask_out,
   input  wire logic [1:0]  cpu_clock_divider_out,
   input  wire logic        cpu_clock_from_crystal_out,
   input  wire logic [2:0]  crystal_freq_code_out,
   input  wire logic [15:0] carrier_freq_100khz_out,
   input  wire logic [2:0]  cpu_clock_log2_div_out,
   input  wire logic        tx_restart_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Out-of-range width codes clamp, so only the legal ones matter here
   function automatic logic [31:0] mask_of(input logic [2:0] w);
      case (w)
         3'h0: mask_of = 32'h00000000;
         3'h1: mask_of = 32'h000000FF;
         3'h2: mask_of = 32'h0000FFFF;
         3'h3: mask_of = 32'h00FFFFFF;
         default: mask_of = 32'hFFFFFFFF;
      endcase
   endfunction

   // ==========================================================
   // Sequences for the multi-step behaviours
   sequence s_packet_end;
      packet_done_in && auto_resend_out && radio_chip_enable_in &&
      transmit_select_in;
   endsequence
   sequence s_read_low_channel;
      reg_read_in && (reg_addr_in == 4'h0);
   endsequence

   a_freq_from_fields: assert property (rst_n_in |=>
      carrier_freq_100khz_out ==
      ((16'h1080 + {7'h00, $past(channel_number_out)})
       << $past(band_select_out)))
      else $error("carrier frequency does not follow channel and band");
   a_restart_on_end: assert property (s_packet_end |=> tx_restart_out)
      else $error("no restart after packet end with resend enabled");
   a_restart_cause: assert property (tx_restart_out |->
      $past(packet_done_in && auto_resend_out && radio_chip_enable_in &&
            transmit_select_in))
      else $error("restart pulse without its cause");
   a_mask_follows_width: assert property (1'b1 |=> rx_address_mask_out ==
      mask_of($past(rx_addr_width_sel_out)))
      else $error("address mask does not match width");
   a_cpu_div_code: assert property (1'b1 |=> cpu_clock_log2_div_out ==
      ($past(cpu_clock_from_crystal_out) ? 3'h0 :
       {1'b0, $past(cpu_clock_divider_out)} + 3'h1))
      else $error("cpu divider code wrong");
   a_boot_crystal_load: assert property (boot_load_in |=>
      crystal_freq_code_out == $past(boot_header_crystal_code_in))
      else $error("crystal code not loaded from boot header");
   a_low_channel_write: assert property (reg_write_in &&
      reg_addr_in == 4'h0 |=> channel_number_out ==
      {$past(channel_number_out[8]), $past(reg_wdata_in)})
      else $error("byte 0 write did not land in channel bits");
   a_unmapped_write: assert property (reg_write_in && reg_addr_in > 4'h9
      |=> $stable(channel_number_out) && $stable(rx_address_out))
      else $error("unmapped write changed a field");
   a_read_low_channel: assert property (s_read_low_channel |=>
      reg_rdata_out == $past(channel_number_out[7:0]))
      else $error("byte 0 read data wrong");
   a_idle_read_zero: assert property (!$past(reg_read_in) |->
      reg_rdata_out == 8'h00)
      else $error("read data not zero outside read cycle");
endmodule // rfc_config_bank_chk

bind rfc_config_bank rfc_config_bank_chk u_chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
   .reg_read_in(reg_read_in), .boot_load_in(boot_load_in),
   .boot_header_crystal_code_in(boot_header_crystal_code_in),
   .radio_chip_enable_in(radio_chip_enable_in),
   .transmit_select_in(transmit_select_in),
   .packet_done_in(packet_done_in), .reg_rdata_out(reg_rdata_out),
   .channel_number_out(channel_number_out),
   .band_select_out(band_select_out), .auto_resend_out(auto_resend_out),
   .rx_addr_width_sel_out(rx_addr_width_sel_out),
   .rx_address_out(rx_address_out),
   .rx_address_mask_out(rx_address_mask_out),
   .cpu_clock_divider_out(cpu_clock_divider_out),
   .cpu_clock_from_crystal_out(cpu_clock_from_crystal_out),
   .crystal_freq_code_out(crystal_freq_code_out),
   .carrier_freq_100khz_out(carrier_freq_100khz_out),
   .cpu_clock_log2_div_out(cpu_clock_log2_div_out),
   .tx_restart_out(tx_restart_out));

// File: rfc_freq_calc.sv
`timescale 1ns/10ps

// ==========================================================
// Carrier frequency in 100 kHz units, registered
module rfc_freq_calc (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [8:0]  channel_number_in,
   input  wire logic        band_select_in,
   output logic      [15:0] freq_100khz_out
);

   logic [15:0] base_sum;

   assign base_sum = rfc_pkg::FREQ_BASE_100K + {7'h00, channel_number_in};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         freq_100khz_out <= 16'h0000;
      end else if (band_select_in) begin
         freq_100khz_out <= {base_sum[14:0], 1'b0};
      end else begin
         freq_100khz_out <= base_sum;
      end
   end

endmodule // rfc_freq_calc

// File: rfc_pkg.sv
package rfc_pkg;

   // ==========================================================
   // Register byte indices (one byte per index)
   localparam logic [3:0] BYTE_CH_LOW   = 4'h0;
   localparam logic [3:0] BYTE_MODE     = 4'h1;
   localparam logic [3:0] BYTE_AFW      = 4'h2;
   localparam logic [3:0] BYTE_RX_LEN   = 4'h3;
   localparam logic [3:0] BYTE_TX_LEN   = 4'h4;
   localparam logic [3:0] BYTE_RXADDR0  = 4'h5;
   localparam logic [3:0] BYTE_RXADDR3  = 4'h8;
   localparam logic [3:0] BYTE_CLOCK    = 4'h9;
   localparam int         NUM_BYTES     = 10;

   // ==========================================================
   // Field positions within their bytes
   localparam int POS_CH8        = 0;
   localparam int POS_BAND       = 1;
   localparam int POS_PWR_LO     = 2;
   localparam int POS_RX_LOW_I   = 4;
   localparam int POS_RESEND     = 5;
   localparam int POS_RX_WIDTH_LO = 0;
   localparam int POS_TX_WIDTH_LO = 4;
   localparam int POS_DIV_LO     = 0;
   localparam int POS_XTAL_SEL   = 2;
   localparam int POS_XTAL_CODE_LO = 3;
   localparam int POS_CRC_EN     = 6;
   localparam int POS_CRC_MODE   = 7;

   // ==========================================================
   // Reset values
   localparam logic [8:0]  RST_CHANNEL   = 9'h06C;
   localparam logic        RST_BAND      = 1'h0;
   localparam logic [1:0]  RST_PWR       = 2'h0;
   localparam logic        RST_LOW_I     = 1'h0;
   localparam logic        RST_RESEND    = 1'h0;
   localparam logic [2:0]  RST_AFW       = 3'h4;
   localparam logic [5:0]  RST_PW        = 6'h20;
   localparam logic [31:0] RST_RX_ADDR   = 32'hE7E7E7E7;
   localparam logic [1:0]  RST_DIV       = 2'h0;
   localparam logic        RST_XTAL_SEL  = 1'h0;
   localparam logic [2:0]  RST_XTAL_CODE = 3'h0;
   localparam logic        RST_CRC_EN    = 1'h1;
   localparam logic        RST_CRC_MODE  = 1'h1;
   localparam logic [7:0]  READ_ZERO     = 8'h00;
   localparam logic [2:0]  RST_LOG2_DIV  = 3'h1;
   localparam logic [31:0] RST_MASK      = 32'hFFFFFFFF;

   // Carrier base in 100 kHz steps: 422.4 MHz = 4224
   localparam logic [15:0] FREQ_BASE_100K = 16'h1080;

endpackage
